// *** core/cluster_regs.vh ***
`ifndef CLUSTER_REGS_VH
`define CLUSTER_REGS_VH

// Register byte offsets
`define CTRL_ADDR      12'h000
`define CELL_CFG_ADDR  12'h004
`define STATUS_ADDR    12'h008
`define LUT_BASE_ADDR  12'h010
`define LUT_LAST_ADDR  12'h02c

// Control fields
`define CTRL_CFG_DONE  0
`define CTRL_CLK_SEL   3:1
`define CTRL_CLK_ROUTE 4
`define CTRL_CE_USED   5
`define CTRL_CE_BUF    7:6
`define CTRL_SR_USED   8
`define CTRL_SR_BUF    10:9
`define CTRL_SR_SYNC   11
`define CTRL_WIDTH     12

// Per-cell configuration fields
`define CFG_OUT_REG    7:0
`define CFG_CE_EN      15:8
`define CFG_SR_EN      23:16
`define CFG_SR_VAL     31:24

// Status fields
`define STAT_FF        7:0
`define STAT_OUT       15:8
`define STAT_CARRY     16
`define STAT_CFG_DONE  17

// Reset values
`define CTRL_RESET     12'h000
`define CELL_CFG_RESET 32'h0000_0000
`define LUT_RESET      16'h0000

`endif

// *** core/logic_cluster.v ***
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "cluster_regs.vh"

module logic_cluster (
    input  wire        clk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  global_buffer,
    input  wire        routing_clk,
    input  wire [7:0]  table_in_0,
    input  wire [7:0]  table_in_1,
    input  wire [7:0]  table_in_2,
    input  wire [7:0]  table_in_3,
    input  wire        carry_in,
    output reg  [7:0]  cell_out,
    output reg         carry_out
);

    // Table lookup for one cell
    function lut_bit;
        input [15:0] tbl;
        input [3:0]  idx;
        begin
            lut_bit = tbl[idx];
        end
    endfunction

    // Word index of a table register; the 3-bit wrap of the subtraction is intended
    function [2:0] lut_index;
        input [11:0] addr;
        begin
            lut_index = addr[4:2] - 3'h4;
        end
    endfunction

    // Aligned address inside the table register window
    function lut_hit;
        input [11:0] addr;
        begin
            lut_hit = (addr >= `LUT_BASE_ADDR) && (addr <= `LUT_LAST_ADDR) &&
                      (addr[1:0] == 2'b00);
        end
    endfunction

    function maj;
        input a;
        input b;
        input c;
        begin
            maj = (a & b) | (a & c) | (b & c);
        end
    endfunction

    reg  [`CTRL_WIDTH-1:0] ctrl_q;
    reg  [31:0]            cell_cfg_q;
    reg  [15:0]            lut_q [0:7];
    reg  [7:0]             ff_q;
    reg  [8:0]             s1_q;
    reg  [8:0]             s2_q;
    reg  [8:0]             s3_q;
    reg  [8:0]             lvl_q;
    reg  [7:0]             lut_res;
    reg  [8:0]             carry;
    reg  [7:0]             ff_d;
    reg  [31:0]            rd_d;
    reg                    map_ok;
    wire [8:0]             stable;
    wire [8:0]             rise;
    wire                   cfg_done;
    wire                   tick;
    wire                   ce_level;
    wire                   sr_level;
    wire                   wr_en;
    wire                   setup;
    wire [2:0]             ce_idx;
    wire [2:0]             sr_idx;
    wire [7:0]             out_reg;
    wire [7:0]             ce_en;
    wire [7:0]             sr_en;
    wire [7:0]             sr_val;
    integer                i;
    integer                j;
    integer                k;

    assign cfg_done = ctrl_q[`CTRL_CFG_DONE];
    assign setup    = psel & ~penable & ~pready;
    assign wr_en    = psel & penable & pready & pwrite & ~pslverr;
    assign out_reg  = cell_cfg_q[`CFG_OUT_REG];
    assign ce_en    = cell_cfg_q[`CFG_CE_EN];
    assign sr_en    = cell_cfg_q[`CFG_SR_EN];
    assign sr_val   = cell_cfg_q[`CFG_SR_VAL];

    // External levels pass three flops; a change counts once stages two and three agree
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q  <= 9'h000;
            s2_q  <= 9'h000;
            s3_q  <= 9'h000;
            lvl_q <= 9'h000;
        end else begin
            s1_q  <= {routing_clk, global_buffer};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= (lvl_q & ~stable) | (s3_q & stable);
        end
    end

    assign stable = ~(s2_q ^ s3_q);
    assign rise   = stable & s3_q & ~lvl_q;

    // Cluster clock becomes an enable pulse on the chosen source's rising edge
    assign tick = ctrl_q[`CTRL_CLK_ROUTE] ? rise[8] : rise[ctrl_q[`CTRL_CLK_SEL]];

    // Only odd buffers reach the enable, only even ones the set/reset
    assign ce_idx = {ctrl_q[`CTRL_CE_BUF], 1'b1};
    assign sr_idx = {ctrl_q[`CTRL_SR_BUF], 1'b0};

    assign ce_level = ctrl_q[`CTRL_CE_USED] ? lvl_q[ce_idx] : 1'b1;
    assign sr_level = ctrl_q[`CTRL_SR_USED] & lvl_q[sr_idx];

    // Tables and carry chain
    always @* begin
        carry[0] = carry_in;
        for (i = 0; i < 8; i = i + 1) begin
            lut_res[i] = lut_bit(lut_q[i],
                                 {table_in_3[i], table_in_2[i],
                                  table_in_1[i], table_in_0[i]});
            carry[i+1] = maj(carry[i], table_in_1[i], table_in_2[i]);
        end
    end

    // Next register state per cell
    always @* begin
        ff_d = ff_q;
        for (j = 0; j < 8; j = j + 1) begin
            if (!cfg_done) begin
                ff_d[j] = 1'b0;
            end else if (sr_level && sr_en[j] && !ctrl_q[`CTRL_SR_SYNC]) begin
                ff_d[j] = sr_val[j];
            end else if (tick) begin
                if (sr_level && sr_en[j]) begin
                    ff_d[j] = sr_val[j];
                end else if (!ce_en[j] || ce_level) begin
                    ff_d[j] = lut_res[j];
                end
            end
        end
    end

    // ff_q and cell_out held clear throughout configuration, carry_out is not; asynchronous set/reset does not wait for a tick
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ff_q      <= 8'h00;
            cell_out  <= 8'h00;
            carry_out <= 1'b0;
        end else begin
            ff_q      <= ff_d;
            cell_out  <= cfg_done ? ((out_reg & ff_q) |
                                     (~out_reg & lut_res)) : 8'h00;
            carry_out <= carry[8];
        end
    end

    // Read decode
    always @* begin
        map_ok = 1'b1;
        rd_d   = 32'h0000_0000;
        case (paddr)
            `CTRL_ADDR: begin
                rd_d = {20'h00000, ctrl_q};
            end
            `CELL_CFG_ADDR: begin
                rd_d = cell_cfg_q;
            end
            `STATUS_ADDR: begin
                rd_d = {14'h0000, cfg_done, carry_out, cell_out, ff_q};
            end
            default: begin
                if (lut_hit(paddr)) begin
                    rd_d = {16'h0000, lut_q[lut_index(paddr)]};
                end else begin
                    map_ok = 1'b0;
                end
            end
        endcase
    end

    // Zero-wait APB slave: answer lined up during the setup cycle
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~map_ok;
            if (setup) begin
                prdata <= (map_ok && !pwrite) ? rd_d : 32'h0000_0000;
            end
        end
    end

    // Register writes; status is read-only and ignores writes
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q     <= `CTRL_RESET;
            cell_cfg_q <= `CELL_CFG_RESET;
            for (k = 0; k < 8; k = k + 1) begin
                lut_q[k] <= `LUT_RESET;
            end
        end else if (wr_en) begin
            if (paddr == `CTRL_ADDR) begin
                ctrl_q <= pwdata[`CTRL_WIDTH-1:0];
            end else if (paddr == `CELL_CFG_ADDR) begin
                cell_cfg_q <= pwdata;
            end else if (lut_hit(paddr)) begin
                lut_q[lut_index(paddr)] <= pwdata[15:0];
            end
        end
    end

endmodule

`default_nettype wire

// *** verif/cluster_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module cluster_asserts (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  table_in_1,
    input wire logic [7:0]  table_in_2,
    input wire logic        carry_in,
    input wire logic [7:0]  cell_out,
    input wire logic        carry_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic cfg_q;
    wire  mapped = paddr[1:0] == 2'h0 && (paddr < 12'h00c || (paddr > 12'h00f && paddr < 12'h030));
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cfg_q <= 1'b0;
        else if (psel && penable && pready && pwrite && paddr == 12'h000) cfg_q <= pwdata[0];
    end
    function automatic logic chain(input logic c, input logic [7:0] a, input logic [7:0] b);
        logic r;
        r = c;
        for (int i = 0; i < 8; i++) r = (r & a[i]) | (r & b[i]) | (a[i] & b[i]);
        return r;
    endfunction
    sequence s_setup; psel && !penable; endsequence
    property p_ready; s_setup |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_single; pready |=> !pready; endproperty
    a_single: assert property (p_single) else $error("ready held too long");
    property p_cause; pready |-> $past(psel && !penable); endproperty
    a_cause: assert property (p_cause) else $error("ready without setup");
    property p_err; pready && !mapped |-> pslverr && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ok; pready && mapped |-> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_stray; pslverr |-> pready; endproperty
    a_stray: assert property (p_stray) else $error("error outside access");
    property p_wake; !cfg_q && !$past(cfg_q) && !$past(cfg_q, 2) |-> cell_out == 8'h00; endproperty
    a_wake: assert property (p_wake) else $error("outputs not cleared");
    property p_carry;
        cfg_q && $past(cfg_q) |-> carry_out == chain($past(carry_in), $past(table_in_1),
            $past(table_in_2));
    endproperty
    a_carry: assert property (p_carry) else $error("carry chain wrong");
endmodule
bind logic_cluster cluster_asserts chk_u (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .table_in_1, .table_in_2, .carry_in, .cell_out,
    .carry_out);
`default_nettype wire

// *** verif/global_buffer_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module global_buffer_model (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    input  wire logic [7:0] lvl,
    output logic      [7:0] global_buffer,
    output logic            routing_clk
);
    logic [2:0] cnt_q = 3'h0;
    logic       ph_q = 1'b0;
    // Half period of 8 clk so every level outlasts the 3-flop synchroniser
    always @(posedge clk) begin
        cnt_q <= cnt_q + 3'h1;
        if (!run) ph_q <= 1'b0;
        else if (cnt_q == 3'h7) ph_q <= !ph_q;
    end
    assign global_buffer = lvl | (8'(ph_q) << sel);
    assign routing_clk = ph_q;
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, carry_in = 0, run = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, routing_clk, carry_out;
    logic [7:0] t0 = 0, t1 = 0, t2 = 0, t3 = 0, lvl = 8'h02, cell_out, global_buffer, hold;
    logic [15:0] lut [8];
    int n_mismatch = 0, compares = 0;
    always #2.5 clk = !clk;
    global_buffer_model bm_u (.clk, .run, .sel(3'h4), .lvl, .global_buffer, .routing_clk);
    logic_cluster dut_u (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .global_buffer, .routing_clk, .table_in_0(t0), .table_in_1(t1),
        .table_in_2(t2), .table_in_3(t3), .carry_in, .cell_out, .carry_out);
    function automatic logic [7:0] expo();
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = lut[i][{t3[i], t2[i], t1[i], t0[i]}];
        return r;
    endfunction
    function automatic logic chain_exp();
        logic c;
        c = carry_in;
        for (int i = 0; i < 8; i++) c = (c & t1[i]) | (c & t2[i]) | (t1[i] & t2[i]);
        return c;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic e);
        int k;
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            end_sim;
        end
        rd = prdata;
        check(pslverr, e);
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    initial begin
        void'($urandom(47));
        repeat (5) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        apb(0, 12'h000, 0, 0);
        check(rd, 0);
        apb(0, 12'h004, 0, 0);
        check(rd, 0);
        apb(1, 12'h030, 32'h1, 1);
        apb(0, 12'h030, 0, 1);
        check(rd, 0);
        for (int i = 0; i < 8; i++) begin
            lut[i] = 16'($urandom);
            apb(1, 12'(16 + 4 * i), {16'h0, lut[i]}, 0);
        end
        apb(0, 12'h02c, 0, 0);
        check(rd, {16'h0, lut[7]});
        apb(1, 12'h000, 32'h1, 0);
        repeat (40) begin
            t0 <= $urandom;
            t1 <= $urandom;
            t2 <= $urandom;
            t3 <= $urandom;
            carry_in <= $urandom;
            repeat (2) @(posedge clk);
            check(cell_out, expo());
        end
        apb(0, 12'h008, 0, 0);
        check(rd, {14'h0, 1'b1, chain_exp(), expo(), 8'h00});
        // Clock from buffer 4, enable from buffer 1, async set/reset from buffer 2
        apb(1, 12'h004, 32'h5aff_ffff, 0);
        apb(1, 12'h000, 32'h329, 0);
        run <= 1;
        repeat (40) @(posedge clk);
        check(cell_out, expo());
        hold = expo();
        lvl <= 8'h00;
        repeat (8) @(posedge clk);
        t0 <= ~t0;
        repeat (40) @(posedge clk);
        check(cell_out, hold);
        lvl <= 8'h02;
        repeat (40) @(posedge clk);
        check(cell_out, expo());
        run <= 0;
        lvl <= 8'h06;
        repeat (10) @(posedge clk);
        check(cell_out, 8'h5a);
        // Synchronous set/reset, clock from routing: nothing moves without a tick
        apb(1, 12'h000, 32'hb39, 0);
        lvl <= 8'h02;
        run <= 1;
        repeat (40) @(posedge clk);
        check(cell_out, expo());
        run <= 0;
        repeat (8) @(posedge clk);
        lvl <= 8'h06;
        repeat (10) @(posedge clk);
        check(cell_out, expo());
        run <= 1;
        repeat (40) @(posedge clk);
        check(cell_out, 8'h5a);
        apb(1, 12'h000, 32'h0, 0);
        repeat (4) @(posedge clk);
        check(cell_out, 8'h00);
        nrst <= 0;
        repeat (2) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        apb(0, 12'h004, 0, 0);
        check(rd, 0);
        end_sim;
    end
endmodule
`default_nettype wire
